// ===== common/rtc_pkg.sv
// shared constants and types of the real-time clock register slice
package rtc_pkg;

    // ========================================================
    // apb geometry
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned IDX_LSB       = 2;
    localparam int unsigned IDX_W         = 4;

    // ========================================================
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_XFER0    = 4'h0;
    localparam logic [IDX_W-1:0] IDX_XFER3    = 4'h3;
    localparam logic [IDX_W-1:0] IDX_CTRL     = 4'h4;
    localparam logic [IDX_W-1:0] IDX_OSC_CTRL = 4'h5;
    localparam logic [IDX_W-1:0] IDX_LOAD_CFG = 4'h6;
    localparam logic [IDX_W-1:0] IDX_PIN_CFG  = 4'h7;
    localparam logic [IDX_W-1:0] IDX_MATCH0   = 4'h8;
    localparam logic [IDX_W-1:0] IDX_MATCH3   = 4'hb;
    localparam int unsigned      NUM_BYTES    = 4;

    // ========================================================
    // field positions
    localparam int unsigned CFG_AUTO_BIT   = 7;
    localparam int unsigned CFG_READY_BIT  = 6;
    localparam int unsigned CFG_CAP_W      = 4;
    localparam int unsigned CTRL_SNAP_BIT  = 0;
    localparam int unsigned CTRL_LOAD_BIT  = 1;
    localparam int unsigned CTRL_FLAG_BIT  = 2;
    localparam int unsigned CTRL_MEN_BIT   = 3;
    localparam int unsigned CTRL_RUN_BIT   = 4;
    localparam int unsigned OSC_MODE_BIT   = 6;

    // ========================================================
    // values
    localparam logic [7:0] PIN_SHORT_VAL   = 8'he7;
    localparam logic [7:0] PIN_NORMAL_VAL  = 8'h67;
    localparam logic [7:0] PIN_RESET_VAL   = 8'h67;
    localparam logic [3:0] CAP_RESET_VAL   = 4'h0;

    // ========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned STEP_TIME_NS   = 1000;
    localparam int unsigned STEP_CYCLES    = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STEP_CNT_W     = 8;

    // ========================================================
    // types
    typedef enum logic [0:0] {
        STEP_IDLE = 1'b0,
        STEP_MOVE = 1'b1
    } step_state_t;

    typedef struct packed {
        logic              load;
        logic [DATA_W-1:0] value;
    } timer_load_t;

endpackage

// ===== rtl/cap_stepper.sv
// load capacitance stepper with ready indication
`timescale 1ns/1ps
module cap_stepper
    import rtc_pkg::*;
#(
    parameter int unsigned STEP_CNT = STEP_CYCLES
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 auto_en,
    input  wire logic [CFG_CAP_W-1:0] target,
    output logic      [CFG_CAP_W-1:0] actual_q,
    output logic                      ready_q
);

    step_state_t            state_q, state_d;
    logic [STEP_CNT_W-1:0]  cnt_q, cnt_d;
    logic [CFG_CAP_W-1:0]   actual_d;
    logic                   ready_d;

    // steps one unit per interval toward the target, or jumps when stepping is off
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        actual_d = actual_q;
        if (!auto_en) begin
            actual_d = target;
            state_d  = STEP_IDLE;
            cnt_d    = '0;
        end else if (actual_q == target) begin
            state_d = STEP_IDLE;
            cnt_d   = '0;
        end else if (state_q == STEP_IDLE) begin
            state_d = STEP_MOVE;
            cnt_d   = '0;
        end else if (cnt_q == STEP_CNT_W'(STEP_CNT - 1)) begin
            cnt_d    = '0;
            actual_d = (actual_q < target) ? actual_q + 4'h1 : actual_q - 4'h1;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
        ready_d = (actual_d == target);
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= STEP_IDLE;
            cnt_q    <= '0;
            actual_q <= CAP_RESET_VAL;
            ready_q  <= 1'b1;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            actual_q <= actual_d;
            ready_q  <= ready_d;
        end
    end

    chk_ready_match: assert property (@(posedge pclk) disable iff (!presetn)
        ready_q |-> actual_q == $past(target)) else $error("ready while capacitance differs");

    chk_step_off: assert property (@(posedge pclk) disable iff (!presetn)
        !auto_en |=> actual_q == $past(target)) else $error("capacitance moved while stepping off");

endmodule

// ===== rtl/rtc_timer.sv
// 32-bit timer advanced by slow clock ticks, with preset
`timescale 1ns/1ps
module rtc_timer
    import rtc_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             tick,
    input  wire logic             run,
    input  wire timer_load_t      preset,
    output logic      [WIDTH-1:0] count_q
);

    logic [WIDTH-1:0] count_d;

    // preset has priority over a tick in the same cycle
    always_comb begin
        count_d = count_q;
        if (preset.load) begin
            count_d = preset.value[WIDTH-1:0];
        end else if (tick && run) begin
            count_d = count_q + 1'b1;
        end
    end

    // timer register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    chk_timer_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!preset.load && !(tick && run)) |=> $stable(count_q)) else $error("timer changed without cause");

endmodule

// ===== rtl/rtc_regs.sv
// apb register slice of the real-time clock: oscillator config, timer transfer, match value
//
// Functional notes
// - bit 7 enables automatic capacitance stepping
// - bit 6 ready when capacitance reaches target
// - config bits 5:4 read zero, ignore writes
// - bits 3:0 hold target load capacitance
// - writing 0xe7 shorts the oscillator pins
// - writing 0x67 restores normal oscillator pins
// - four transfer bytes form 32-bit timer value
// - transfer moves only on a byte write or snapshot
// - transfer bytes at 0x00-0x03, lsb first
// - match bytes at 0x08-0x0b, lsb first
// - config at 0x06, pin config at 0x07
// - load strobe presets timer, then self-clears
// - snapshot strobe copies timer, then self-clears
// - mode bit selects crystal or self-oscillate
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module rtc_regs
    import rtc_pkg::*;
#(
    parameter int unsigned STEP_CNT = STEP_CYCLES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [DATA_W-1:0]     pwdata,
    output logic      [DATA_W-1:0]     prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  rtc_tick,
    output logic                       osc_mode_select,
    output logic                       osc_pin_short,
    output logic      [CFG_CAP_W-1:0]  load_cap_actual,
    output logic                       match_event_flag,
    output logic      [DATA_W-1:0]     timer_value
);

    // ========================================================
    // state
    logic [DATA_W-1:0]     prdata_q, prdata_d;
    logic                  pready_q, pready_d;
    logic                  pslverr_q, pslverr_d;
    logic [DATA_W-1:0]     xfer_q, xfer_d;
    logic [DATA_W-1:0]     match_q, match_d;
    logic                  cfg_auto_q, cfg_auto_d;
    logic [CFG_CAP_W-1:0]  cfg_cap_q, cfg_cap_d;
    logic [7:0]            pin_q, pin_d;
    logic                  pin_short_q, pin_short_d;
    logic                  osc_mode_q, osc_mode_d;
    logic                  run_q, run_d;
    logic                  men_q, men_d;
    logic                  load_stb_q, load_stb_d;
    logic                  snap_stb_q, snap_stb_d;
    logic                  flag_q, flag_d;
    logic                  tick_s1_q, tick_s2_q, tick_s3_q;

    logic [IDX_W-1:0]      idx;
    logic                  mapped;
    logic                  access;
    logic                  wr_en;
    logic                  tick_pulse;
    logic                  cap_ready;
    logic                  hit;
    logic [DATA_W-1:0]     timer_count;
    logic [CFG_CAP_W-1:0]  cap_actual;
    timer_load_t           preset;

    // ========================================================
    // address decode
    assign idx    = paddr[IDX_LSB +: IDX_W];
    assign mapped = (paddr[IDX_LSB-1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_LSB+IDX_W] == 2'h0)
                    && (idx <= IDX_MATCH3);
    assign access = psel && penable;
    // a write lands at the edge where pready is seen high
    assign wr_en  = access && pready_q && pwrite && !pslverr_q;

    // ========================================================
    // slow clock tick synchroniser and rising edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
            tick_s3_q <= 1'b0;
        end else begin
            tick_s1_q <= rtc_tick;
            tick_s2_q <= tick_s1_q;
            tick_s3_q <= tick_s2_q;
        end
    end
    assign tick_pulse = tick_s2_q && !tick_s3_q;

    // ========================================================
    // sub blocks
    assign preset = '{load: load_stb_q,
                      value: xfer_q};

    rtc_timer #(
        .WIDTH   (DATA_W)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick_pulse),
        .run     (run_q),
        .preset  (preset),
        .count_q (timer_count)
    );

    cap_stepper #(
        .STEP_CNT (STEP_CNT)
    ) u_stepper (
        .pclk     (pclk),
        .presetn  (presetn),
        .auto_en  (cfg_auto_q),
        .target   (cfg_cap_q),
        .actual_q (cap_actual),
        .ready_q  (cap_ready)
    );

    // equality against the match value counts only while enabled
    assign hit = men_q && (timer_count == match_q);

    // ========================================================
    // apb handshake: one wait state, read data and error registered
    always_comb begin
        pready_d  = access && !pready_q;
        pslverr_d = access && !pready_q && !mapped;
        prdata_d  = '0;
        if (access && !pready_q && !pwrite && mapped) begin
            if (idx <= IDX_XFER3) begin
                prdata_d[7:0] = xfer_q[8*idx[1:0] +: 8];
            end else if (idx >= IDX_MATCH0) begin
                prdata_d[7:0] = match_q[8*idx[1:0] +: 8];
            end else begin
                case (idx)
                    IDX_CTRL: begin
                        prdata_d[CTRL_SNAP_BIT] = snap_stb_q;
                        prdata_d[CTRL_LOAD_BIT] = load_stb_q;
                        prdata_d[CTRL_FLAG_BIT] = flag_q;
                        prdata_d[CTRL_MEN_BIT]  = men_q;
                        prdata_d[CTRL_RUN_BIT]  = run_q;
                    end
                    IDX_OSC_CTRL: begin
                        prdata_d[OSC_MODE_BIT] = osc_mode_q;
                    end
                    IDX_LOAD_CFG: begin
                        prdata_d[CFG_AUTO_BIT]    = cfg_auto_q;
                        prdata_d[CFG_READY_BIT]   = cap_ready;
                        prdata_d[CFG_CAP_W-1:0]   = cfg_cap_q;
                    end
                    IDX_PIN_CFG: begin
                        prdata_d[7:0] = pin_q;
                    end
                    default: begin
                        prdata_d = '0;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // register writes, strobe completion and match flag
    always_comb begin
        xfer_d      = xfer_q;
        match_d     = match_q;
        cfg_auto_d  = cfg_auto_q;
        cfg_cap_d   = cfg_cap_q;
        pin_d       = pin_q;
        pin_short_d = pin_short_q;
        osc_mode_d  = osc_mode_q;
        run_d       = run_q;
        men_d       = men_q;
        flag_d      = flag_q;
        // strobes finish one cycle after being raised
        load_stb_d  = 1'b0;
        snap_stb_d  = 1'b0;
        if (snap_stb_q) begin
            xfer_d = timer_count;
        end
        if (wr_en) begin
            for (int i = 0; i < NUM_BYTES; i++) begin
                if (idx == IDX_XFER0 + 4'(i)) begin
                    xfer_d[8*i +: 8] = pwdata[7:0];
                end
                if (idx == IDX_MATCH0 + 4'(i)) begin
                    match_d[8*i +: 8] = pwdata[7:0];
                end
            end
            case (idx)
                IDX_CTRL: begin
                    snap_stb_d = pwdata[CTRL_SNAP_BIT];
                    load_stb_d = pwdata[CTRL_LOAD_BIT];
                    men_d      = pwdata[CTRL_MEN_BIT];
                    run_d      = pwdata[CTRL_RUN_BIT];
                    if (pwdata[CTRL_FLAG_BIT] || !pwdata[CTRL_MEN_BIT]) begin
                        flag_d = 1'b0;
                    end
                end
                IDX_OSC_CTRL: begin
                    osc_mode_d = pwdata[OSC_MODE_BIT];
                end
                IDX_LOAD_CFG: begin
                    cfg_auto_d = pwdata[CFG_AUTO_BIT];
                    cfg_cap_d  = pwdata[CFG_CAP_W-1:0];
                end
                IDX_PIN_CFG: begin
                    pin_d = pwdata[7:0];
                    if (pwdata[7:0] == PIN_SHORT_VAL) begin
                        pin_short_d = 1'b1;
                    end else if (pwdata[7:0] == PIN_NORMAL_VAL) begin
                        pin_short_d = 1'b0;
                    end
                end
                default: begin
                    pin_d = pin_q;
                end
            endcase
        end
        // a match in the clearing cycle still sets the flag
        if (hit) begin
            flag_d = 1'b1;
        end
    end

    // ========================================================
    // register bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q    <= '0;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            xfer_q      <= '0;
            match_q     <= '0;
            cfg_auto_q  <= 1'b0;
            cfg_cap_q   <= CAP_RESET_VAL;
            pin_q       <= PIN_RESET_VAL;
            pin_short_q <= 1'b0;
            osc_mode_q  <= 1'b0;
            run_q       <= 1'b0;
            men_q       <= 1'b0;
            load_stb_q  <= 1'b0;
            snap_stb_q  <= 1'b0;
            flag_q      <= 1'b0;
        end else begin
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            xfer_q      <= xfer_d;
            match_q     <= match_d;
            cfg_auto_q  <= cfg_auto_d;
            cfg_cap_q   <= cfg_cap_d;
            pin_q       <= pin_d;
            pin_short_q <= pin_short_d;
            osc_mode_q  <= osc_mode_d;
            run_q       <= run_d;
            men_q       <= men_d;
            load_stb_q  <= load_stb_d;
            snap_stb_q  <= snap_stb_d;
            flag_q      <= flag_d;
        end
    end

    // ========================================================
    // outputs, each from a flip-flop
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign osc_mode_select  = osc_mode_q;
    assign osc_pin_short    = pin_short_q;
    assign load_cap_actual  = cap_actual;
    assign match_event_flag = flag_q;
    assign timer_value      = timer_count;

    // ========================================================
    // checks
    chk_cfg_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (pready_q && !pwrite && idx == IDX_LOAD_CFG) |-> prdata_q[5:4] == 2'h0)
        else $error("unused config bits read nonzero");

    chk_cfg_target_store: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_LOAD_CFG) |=> cfg_cap_q == $past(pwdata[3:0]))
        else $error("target capacitance not stored");

    chk_pin_short_set: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_PIN_CFG && pwdata[7:0] == PIN_SHORT_VAL) |=> osc_pin_short)
        else $error("pins not shorted");

    chk_pin_short_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_PIN_CFG && pwdata[7:0] == PIN_NORMAL_VAL) |=> !osc_pin_short)
        else $error("pins still shorted");

    chk_load_preset: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(load_stb_q) |=> (timer_value == $past(xfer_q)) && !load_stb_q)
        else $error("timer preset missing or strobe stuck");

    chk_snap_copy: assert property (@(posedge pclk) disable iff (!presetn)
        snap_stb_q |=> (xfer_q == $past(timer_count)) && !snap_stb_q)
        else $error("snapshot missing or strobe stuck");

    chk_xfer_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!snap_stb_q && !wr_en) |=> $stable(xfer_q))
        else $error("transfer bytes changed without cause");

    chk_xfer_lsb: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_XFER0) |=> xfer_q[7:0] == $past(pwdata[7:0]))
        else $error("transfer low byte misplaced");

    chk_match_lsb: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_MATCH0) |=> match_q[7:0] == $past(pwdata[7:0]))
        else $error("match low byte misplaced");

    chk_cfg_decode: assert property (@(posedge pclk) disable iff (!presetn)
        (pready_q && paddr[1:0] == 2'h0 && (idx == IDX_LOAD_CFG || idx == IDX_PIN_CFG)
         && paddr[7:6] == 2'h0) |-> !pslverr_q)
        else $error("config register not decoded");

    chk_mode_store: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_OSC_CTRL) |=> osc_mode_select == $past(pwdata[6]))
        else $error("oscillator mode not stored");

    chk_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
        hit |=> match_event_flag)
        else $error("match flag not raised");

    chk_step_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && idx == IDX_LOAD_CFG) |=> cfg_auto_q == $past(pwdata[7]))
        else $error("stepping enable not stored");

endmodule

// ===== bench/rtc_regs_tb_top.sv
// self-checking testbench of the real-time clock register slice
`timescale 1ns/1ps
module rtc_regs_tb_top
    import rtc_pkg::*;
;
    // ========================================================
    // signals
    logic                 pclk;
    logic                 presetn;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [ADDR_W-1:0]    paddr;
    logic [DATA_W-1:0]    pwdata;
    logic [DATA_W-1:0]    prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 rtc_tick;
    logic                 osc_mode_select;
    logic                 osc_pin_short;
    logic [CFG_CAP_W-1:0] load_cap_actual;
    logic                 match_event_flag;
    logic [DATA_W-1:0]    timer_value;
    logic [DATA_W-1:0]    rd_v;
    logic                 er_v;
    int                   err_total;
    int                   n_compared;

    // short capacitance step keeps the run brief
    rtc_regs #(.STEP_CNT(4)) u_dut (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .rtc_tick         (rtc_tick),
        .osc_mode_select  (osc_mode_select),
        .osc_pin_short    (osc_pin_short),
        .load_cap_actual  (load_cap_actual),
        .match_event_flag (match_event_flag),
        .timer_value      (timer_value)
    );

    // ========================================================
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (50000) @(posedge pclk);
        err_total++;
        results();
    end

    // ========================================================
    // helpers
    task automatic results();
        if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is seen at the sampling edge
    task automatic xfer(input logic w, input logic [7:0] adr, input logic [7:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= adr;
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                results();
            end
            @(posedge pclk);
        end
        // answer taken at the edge where pready is seen high, then released
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        xfer(1'b1, {2'b00, i, 2'b00}, d, rd_v, er_v);
        chk("write error", 32'h0, {31'h0, er_v});
    endtask

    task automatic rchk(input logic [3:0] i, input logic [31:0] e, input string nm);
        xfer(1'b0, {2'b00, i, 2'b00}, 8'h00, rd_v, er_v);
        chk(nm, e, rd_v);
        chk("read error", 32'h0, {31'h0, er_v});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // slow clock edges, three cycles high and low, then sync settle
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge pclk);
            rtc_tick <= 1'b1;
            repeat (3) @(posedge pclk);
            rtc_tick <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        cyc(4);
    endtask

    // ========================================================
    // main sequence
    initial begin
        int n;
        err_total = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rtc_tick = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        for (int i = 0; i < 12; i++) if (i < 4 || i > 7) rchk(i[3:0], 32'h0, "byte reset");
        rchk(IDX_LOAD_CFG, 32'h40, "cfg reset");
        rchk(IDX_PIN_CFG, 32'h67, "pin reset");
        chk("short reset", 32'h0, {31'h0, osc_pin_short});
        // transfer and match bytes hold their own values
        for (int i = 0; i < 4; i++) wr(i[3:0], 8'h11 * (i + 1));
        for (int i = 8; i < 12; i++) wr(i[3:0], 8'ha0 + i[7:0]);
        for (int i = 0; i < 4; i++) rchk(i[3:0], 32'h11 * (i + 1), "xfer byte");
        for (int i = 8; i < 12; i++) rchk(i[3:0], 32'ha0 + i, "match byte");
        chk("timer before load", 32'h0, timer_value);
        // load strobe presets the timer, lsb in byte 0
        wr(IDX_CTRL, 8'h02);
        cyc(2);
        chk("timer preset", 32'h44332211, timer_value);
        rchk(IDX_CTRL, 32'h0, "load strobe cleared");
        // run, stop, then snapshot back into the bytes
        wr(IDX_CTRL, 8'h10);
        ticks(5);
        chk("timer count", 32'h44332216, timer_value);
        wr(IDX_CTRL, 8'h00);
        rchk(0, 32'h11, "byte before snap");
        wr(IDX_CTRL, 8'h01);
        cyc(2);
        for (int i = 0; i < 4; i++) rchk(i[3:0], (32'h44332216 >> (8 * i)) & 32'hff, "snapshot");
        // match value two ticks ahead, enable off while rewriting
        for (int i = 8; i < 12; i++) wr(i[3:0], (32'h44332218 >> (8 * (i - 8))) & 32'hff);
        wr(IDX_CTRL, 8'h18);
        ticks(1);
        chk("flag early", 32'h0, {31'h0, match_event_flag});
        ticks(1);
        chk("flag on equal", 32'h1, {31'h0, match_event_flag});
        ticks(1);
        chk("flag sticky", 32'h1, {31'h0, match_event_flag});
        rchk(IDX_CTRL, 32'h1c, "ctrl flag read");
        // write one clears the flag while the match stays enabled
        wr(IDX_CTRL, 8'h1c);
        cyc(1);
        chk("flag w1c", 32'h0, {31'h0, match_event_flag});
        wr(IDX_CTRL, 8'h00);
        wr(IDX_MATCH0, 8'h19);
        wr(IDX_CTRL, 8'h08);
        cyc(1);
        chk("flag again", 32'h1, {31'h0, match_event_flag});
        // clear while still equal: the set wins
        wr(IDX_CTRL, 8'h00);
        cyc(1);
        chk("flag set wins", 32'h1, {31'h0, match_event_flag});
        wr(IDX_CTRL, 8'h04);
        cyc(1);
        chk("flag cleared", 32'h0, {31'h0, match_event_flag});
        // load config: read-only bits ignored, direct target
        wr(IDX_LOAD_CFG, 8'h7f);
        rchk(IDX_LOAD_CFG, 32'h4f, "cfg direct");
        chk("cap direct", 32'hf, {28'h0, load_cap_actual});
        // automatic stepping down to the new target
        wr(IDX_LOAD_CFG, 8'h83);
        rchk(IDX_LOAD_CFG, 32'h83, "cfg stepping");
        n = 0;
        while (load_cap_actual !== 4'h3 && n < 200) begin
            cyc(1);
            n++;
        end
        chk("cap stepped", 32'h3, {28'h0, load_cap_actual});
        cyc(2);
        rchk(IDX_LOAD_CFG, 32'hc3, "cfg ready");
        // pin short codes
        wr(IDX_PIN_CFG, 8'he7);
        cyc(1);
        chk("short on", 32'h1, {31'h0, osc_pin_short});
        wr(IDX_PIN_CFG, 8'h12);
        rchk(IDX_PIN_CFG, 32'h12, "pin other");
        chk("short held", 32'h1, {31'h0, osc_pin_short});
        wr(IDX_PIN_CFG, 8'h67);
        cyc(1);
        chk("short off", 32'h0, {31'h0, osc_pin_short});
        // oscillator mode bit
        wr(IDX_OSC_CTRL, 8'h40);
        rchk(IDX_OSC_CTRL, 32'h40, "mode read");
        chk("mode set", 32'h1, {31'h0, osc_mode_select});
        wr(IDX_OSC_CTRL, 8'h00);
        cyc(1);
        chk("mode clear", 32'h0, {31'h0, osc_mode_select});
        // refused addresses
        xfer(1'b0, 8'h30, 8'h00, rd_v, er_v);
        chk("unmapped", 32'h1, {31'h0, er_v});
        xfer(1'b1, 8'h19, 8'h05, rd_v, er_v);
        chk("misaligned", 32'h1, {31'h0, er_v});
        xfer(1'b1, 8'h58, 8'h05, rd_v, er_v);
        chk("high bits", 32'h1, {31'h0, er_v});
        rchk(IDX_LOAD_CFG, 32'hc3, "cfg untouched");
        results();
    end
endmodule
